// >>> src/bufctl_map.svh
`ifndef BUFCTL_MAP_SVH
`define BUFCTL_MAP_SVH

// ****************************************************************
// Reset and timing counts
// ****************************************************************
`define RESET_HOLD_CLOCKS      8
`define GRANT_TO_DRIVE_CLOCKS  2
`define BCLK_PERIOD_NS         25

// ****************************************************************
// Field positions
// ****************************************************************
`define UPPER_ADDR_LSB         10
`define UPPER_ADDR_MSB         31
`define LOWER_ADDR_LSB         2
`define LOWER_ADDR_MSB         9

// ****************************************************************
// Reset values of the pin controls
// ****************************************************************
`define STROBE_RESET           1'b1
`define DIRECTION_RESET        1'b1
`define LANE_ENABLE_RESET_N    3'h7

// ****************************************************************
// Default decode values
// ****************************************************************
`define SLOT_DECODE_DEFAULT    10'h000
`define GENERAL_DECODE_DEFAULT 8'h00

`endif

// >>> src/bufctl_pkg.sv
package bufctl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_GRANTED = 3'b001,
        ST_STROBE  = 3'b011,
        ST_ADDR    = 3'b010,
        ST_DATA    = 3'b110,
        ST_DONE    = 3'b111
    } master_state_type;

    typedef struct packed {
        logic [31:0] address;
        logic [31:0] write_data;
        logic [3:0]  byte_enables_n;
        logic        is_write;
    } master_request_type;

    typedef struct packed {
        logic [11:2] address;
        logic [3:0]  byte_enables_n;
    } slave_decode_type;

endpackage

// >>> src/reset_sync.sv
module reset_sync (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      rst_sync_n
);

    logic stage1_q;

    // Async assertion, clocked release; only the second stage reads stage1_q.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage1_q   <= 1'b1;
            rst_sync_n <= stage1_q;
        end
    end

endmodule

// >>> src/slave_decoder.sv
`include "bufctl_map.svh"

module slave_decoder
    import bufctl_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire slave_decode_type sample,
    input  wire logic             sample_valid,
    input  wire logic [11:2]      slot_base,
    input  wire logic [3:0]       slot_be_n,
    input  wire logic [9:2]       general_base,
    output logic                  slot_hit_q,
    output logic                  general_hit_q
);

    function automatic logic match_slot(input slave_decode_type s, input logic [11:2] base,
                                        input logic [3:0] be_n);
        match_slot = (s.address == base) && (s.byte_enables_n == be_n);
    endfunction

    function automatic logic match_general(input slave_decode_type s, input logic [9:2] base);
        match_general = (s.address[9:2] == base);
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slot_hit_q    <= 1'b0;
            general_hit_q <= 1'b0;
        end else begin
            slot_hit_q    <= sample_valid && match_slot(sample, slot_base, slot_be_n); // R10 R13
            general_hit_q <= sample_valid && match_general(sample, general_base);     // R11
        end
    end

endmodule

// >>> src/bus_buffer_control.sv
// Summary of operation
// R1: Reset held at least eight bus clocks.
// R2: Reset is synchronised before internal use.
// R3: Reset sets all registers and states.
// R4: Upper 22 data lines carry LA31..10.
// R5: Device controls transceivers and latches always.
// R6: Data lines float after reset.
// R7: Address 11..10 are slave-only inputs.
// R8: Master drives address 9..2 directly.
// R9: Slave latches pipelined address itself.
// R10: Slot decode uses address 11..2, enables.
// R11: General decode uses address 9..2 only.
// R12: Master drives active-low byte enables.
// R13: Slave decodes registers from enables, address.
// R14: Address and enables float after reset.
// R15: Latches reload at each master transfer.
// R16: Strobe low one clock before start.
// R17: Strobe stays high in slave mode.
// R18: Strobe inactive high after reset.
// R19: Direction low when device drives bus.
// R20: Direction high for inbound, after reset.
// R21: Lane enables only during transfers.
// R22: Drive lines two clocks after grant.
// R23: Separate enables lanes 0, 1, 2-3.
`include "bufctl_map.svh"

module bus_buffer_control
    import bufctl_pkg::*;
#(
    parameter int GRANT_DELAY = `GRANT_TO_DRIVE_CLOCKS
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               master_start,
    input  wire master_request_type master_request,
    input  wire logic               cycle_end,
    input  wire logic               slave_cycle,
    input  wire logic               slave_write,
    input  wire logic [11:2]        slot_base,
    input  wire logic [3:0]         slot_be_n,
    input  wire logic [9:2]         general_base,
    input  wire logic               bus_grant_n,
    input  wire logic [31:0]        bus_data_upper_addr_lines_in,
    input  wire logic [11:10]       slave_upper_decode_addr_inputs,
    input  wire logic [9:2]         lower_addr_lines_in,
    input  wire logic [3:0]         byte_lane_enables_n_in,
    output logic [31:0]             bus_data_upper_addr_lines_out,
    output logic                    bus_data_upper_addr_lines_oe,
    output logic [9:2]              lower_addr_lines_out,
    output logic                    lower_addr_lines_oe,
    output logic [3:0]              byte_lane_enables_n_out,
    output logic                    byte_lane_enables_n_oe,
    output logic                    upper_addr_latch_strobe_n,
    output logic                    transceiver_direction,
    output logic                    lane23_transceiver_enable_n,
    output logic                    lane1_transceiver_enable_n,
    output logic                    lane0_transceiver_enable_n,
    output logic                    start_n,
    output logic                    slot_hit,
    output logic                    general_hit,
    output logic [31:0]             read_data,
    output logic                    master_busy
);

    // ****************************************************************
    // Reset and pin synchronisers
    // ****************************************************************
    logic               rst_sync_n;
    logic               grant_meta_q;
    logic               grant_q;
    logic [31:0]        data_meta_q;
    logic [31:0]        data_sync_q;
    slave_decode_type   decode_meta_q;
    slave_decode_type   decode_sync_q;
    master_state_type   state_q;
    master_request_type request_q;
    logic [1:0]         grant_count_q;
    logic               slave_active_q;

    reset_sync u_reset_sync (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .rst_sync_n (rst_sync_n)
    ); // R2

    // Pins come from the bus side, so each passes two stages before use.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            grant_meta_q  <= 1'b0;
            grant_q       <= 1'b0;
            data_meta_q   <= 32'h0;
            data_sync_q   <= 32'h0;
            decode_meta_q <= '0;
            decode_sync_q <= '0;
        end else begin
            grant_meta_q  <= ~bus_grant_n;
            grant_q       <= grant_meta_q;
            data_meta_q   <= bus_data_upper_addr_lines_in;
            data_sync_q   <= data_meta_q;
            decode_meta_q <= {slave_upper_decode_addr_inputs, lower_addr_lines_in,
                              byte_lane_enables_n_in}; // R7 R13
            decode_sync_q <= decode_meta_q;
        end
    end

    slave_decoder u_slave_decoder (
        .clk_sys       (clk_sys),
        .rst_n         (rst_sync_n),
        .sample        (decode_sync_q),
        .sample_valid  (slave_active_q),
        .slot_base     (slot_base),
        .slot_be_n     (slot_be_n),
        .general_base  (general_base),
        .slot_hit_q    (slot_hit),
        .general_hit_q (general_hit)
    ); // R10 R11

    // ****************************************************************
    // Master sequencer
    // ****************************************************************
    // IDLE waits for a request, GRANTED counts grant clocks, STROBE lowers
    // the latch strobe, ADDR drops start, DATA runs until cycle_end.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q       <= ST_IDLE; // R3
            request_q     <= '0;
            grant_count_q <= 2'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    grant_count_q <= 2'h0;
                    // A slave access seen in the same clock wins.
                    if (master_start && !slave_active_q && !slave_cycle) begin
                        request_q <= master_request;
                        state_q   <= ST_GRANTED;
                    end
                end
                ST_GRANTED: begin
                    if (grant_q) begin
                        if (grant_count_q == 2'(GRANT_DELAY - 1)) begin
                            state_q <= ST_STROBE; // R22
                        end else begin
                            grant_count_q <= grant_count_q + 2'h1;
                        end
                    end else begin
                        grant_count_q <= 2'h0;
                    end
                end
                ST_STROBE: state_q <= ST_ADDR; // R16
                ST_ADDR:   state_q <= ST_DATA;
                ST_DATA: begin
                    if (cycle_end) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE:   state_q <= ST_IDLE;
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            slave_active_q <= 1'b0;
        end else begin
            slave_active_q <= slave_cycle && (state_q == ST_IDLE);
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    logic driving_master;
    logic strobe_phase;
    logic data_phase;

    assign driving_master = (state_q == ST_STROBE) || (state_q == ST_ADDR)
                            || (state_q == ST_DATA);
    assign strobe_phase   = (state_q == ST_GRANTED) && grant_q
                            && (grant_count_q == 2'(GRANT_DELAY - 1));
    assign data_phase     = (state_q == ST_ADDR) || (state_q == ST_DATA);

    // The strobe falls one clock ahead of start and stays low to cycle end.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            upper_addr_latch_strobe_n <= `STROBE_RESET; // R18
            start_n                   <= 1'b1;
        end else begin
            upper_addr_latch_strobe_n <= ~(strobe_phase || (driving_master
                                           && !(state_q == ST_DATA && cycle_end))); // R15 R16 R17
            start_n                   <= ~(state_q == ST_STROBE);
        end
    end

    // Upper address shares the data lines until the latch has captured it.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_data_upper_addr_lines_out <= 32'h0;
            bus_data_upper_addr_lines_oe  <= 1'b0; // R6
        end else begin
            if (strobe_phase || state_q == ST_STROBE) begin
                bus_data_upper_addr_lines_out <= {request_q.address[31:10], 10'h000}; // R4
                bus_data_upper_addr_lines_oe  <= 1'b1;
            end else if (data_phase && request_q.is_write && !cycle_end) begin
                bus_data_upper_addr_lines_out <= request_q.write_data;
                bus_data_upper_addr_lines_oe  <= 1'b1;
            end else if (slave_active_q && !slave_write) begin
                bus_data_upper_addr_lines_out <= 32'h0;
                bus_data_upper_addr_lines_oe  <= 1'b1;
            end else begin
                bus_data_upper_addr_lines_oe  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lower_addr_lines_out    <= 8'h00;
            lower_addr_lines_oe     <= 1'b0; // R14
            byte_lane_enables_n_out <= 4'hf;
            byte_lane_enables_n_oe  <= 1'b0;
        end else begin
            lower_addr_lines_out    <= request_q.address[9:2]; // R8
            lower_addr_lines_oe     <= driving_master && !cycle_end;
            byte_lane_enables_n_out <= request_q.byte_enables_n; // R12
            byte_lane_enables_n_oe  <= driving_master && !cycle_end;
        end
    end

    logic       outbound;
    logic [3:0] lanes_n;
    logic       active;

    assign outbound = data_phase ? request_q.is_write : (slave_active_q && !slave_write);
    assign lanes_n  = data_phase ? request_q.byte_enables_n : decode_sync_q.byte_enables_n;
    assign active   = (data_phase && !cycle_end) || slave_active_q; // R5

    // Transceivers open only during data phases and slave cycles; direction follows flow.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            transceiver_direction       <= `DIRECTION_RESET; // R20
            lane0_transceiver_enable_n  <= 1'b1; // R21
            lane1_transceiver_enable_n  <= 1'b1;
            lane23_transceiver_enable_n <= 1'b1;
        end else begin
            transceiver_direction       <= ~outbound; // R19 R20
            lane0_transceiver_enable_n  <= ~(active && !lanes_n[0]); // R23
            lane1_transceiver_enable_n  <= ~(active && !lanes_n[1]);
            lane23_transceiver_enable_n <= ~(active && !(lanes_n[2] && lanes_n[3]));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            read_data   <= 32'h0;
            master_busy <= 1'b0;
        end else begin
            if (state_q == ST_DATA && cycle_end && !request_q.is_write) begin
                read_data <= data_sync_q;
            end
            master_busy <= (state_q != ST_IDLE);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence strobe_falls;
        $fell(upper_addr_latch_strobe_n);
    endsequence

    sequence start_falls_next;
        ##1 $fell(start_n);
    endsequence

    AST_STROBE_BEFORE_START: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R16
        strobe_falls |-> start_falls_next) else $error("start did not follow strobe");

    AST_SLAVE_STROBE_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R17
        slave_active_q |=> upper_addr_latch_strobe_n) else $error("strobe low in slave");

    AST_ADDR_ON_DATA: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R4 R15
        $fell(upper_addr_latch_strobe_n) |-> bus_data_upper_addr_lines_oe
        && bus_data_upper_addr_lines_out[31:10] == request_q.address[31:10])
        else $error("upper address not on data lines");

    AST_DIR_OUT_LOW: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R19
        (data_phase && request_q.is_write) |=> !transceiver_direction)
        else $error("direction not outbound");

    AST_DIR_IN_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R20
        (state_q == ST_IDLE && !slave_active_q) |=> transceiver_direction)
        else $error("direction not inbound at rest");

    AST_LANES_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R21
        (state_q == ST_IDLE && !slave_active_q) |=> lane0_transceiver_enable_n
        && lane1_transceiver_enable_n && lane23_transceiver_enable_n)
        else $error("lane enable while idle");

    AST_GRANT_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R22
        (state_q == ST_GRANTED && !grant_q) |=> state_q != ST_STROBE)
        else $error("drive began without grant");

    AST_LOWER_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R8 R12
        (state_q == ST_ADDR) |=> lower_addr_lines_oe
        && lower_addr_lines_out == request_q.address[9:2]
        && byte_lane_enables_n_out == request_q.byte_enables_n)
        else $error("master address or enables not driven");

    AST_SLAVE_FLOAT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R7 R13 R14
        slave_active_q |=> !lower_addr_lines_oe && !byte_lane_enables_n_oe)
        else $error("address driven in slave mode");

    sequence start_back_high;
        ##1 start_n;
    endsequence

    AST_START_ONE_CLOCK: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R16
        $fell(start_n) |-> start_back_high)
        else $error("start held too long");

    AST_STROBE_HELD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R16
        (state_q == ST_DATA && !cycle_end)
        |=> !upper_addr_latch_strobe_n)
        else $error("strobe released early");

    AST_CYCLE_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R12 R16
        (state_q == ST_DATA && cycle_end)
        |=> upper_addr_latch_strobe_n && !lower_addr_lines_oe && !byte_lane_enables_n_oe)
        else $error("pins driven after cycle end");

    AST_LANE_MAP: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R21 R23
        (data_phase && !cycle_end)
        |=> lane0_transceiver_enable_n == request_q.byte_enables_n[0]
        && lane1_transceiver_enable_n == request_q.byte_enables_n[1]
        && lane23_transceiver_enable_n == &request_q.byte_enables_n[3:2])
        else $error("lane enables wrong");

    AST_SLAVE_READ_OUT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R5 R19
        (slave_active_q && !slave_write)
        |=> bus_data_upper_addr_lines_oe && !transceiver_direction)
        else $error("slave read not driven");

    AST_HIT_ONLY_SLAVE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R10 R11
        !slave_active_q
        |=> !slot_hit && !general_hit)
        else $error("hit outside slave cycle");

endmodule

// >>> tb/bus_side_model.sv
module bus_side_model
    import bufctl_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             grant_slow,
    input  wire logic             master_busy,
    input  wire logic             start_n,
    input  wire logic             slave_mode,
    input  wire logic [31:0]      bus_word,
    input  wire slave_decode_type slave_addr,
    input  wire logic [31:0]      data_out,
    input  wire logic             data_oe,
    input  wire logic [9:2]       la_out,
    input  wire logic             la_oe,
    input  wire logic [3:0]       be_out,
    input  wire logic             be_oe,
    output logic                  bus_grant_n,
    output logic [31:0]           data_in,
    output logic [11:10]          upper_in,
    output logic [9:2]            la_in,
    output logic [3:0]            be_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] noise_q = 32'h0;
    logic [3:0]  wait_q = 4'h0;
    logic [9:2]  seen_la_q = 8'h00;
    initial bus_grant_n = 1'b1;
    // Undriven lines toggle every cycle so a stale value can never pass a check.
    always @(negedge clk_sys) begin
        noise_q <= ~noise_q;
        wait_q <= master_busy ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
        bus_grant_n <= !(master_busy && wait_q >= (grant_slow ? 4'h9 : 4'h1));
    end
    // The addressed slave keeps its own copy of the pipelined lower address.
    always @(posedge clk_sys) if (!start_n) seen_la_q <= la_in;
    assign data_in = data_oe ? data_out : (master_busy || slave_mode) ? bus_word : noise_q;
    assign la_in = la_oe ? la_out : slave_mode ? slave_addr.address[9:2] : noise_q[9:2];
    assign be_in = be_oe ? be_out : slave_mode ? slave_addr.byte_enables_n : noise_q[3:0];
    assign upper_in = slave_mode ? slave_addr.address[11:10] : noise_q[11:10];
endmodule

// >>> tb/tb.sv
module tb
    import bufctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n, master_start, cycle_end, slave_cycle, slave_write, bus_grant_n, grant_slow;
    master_request_type master_request;
    slave_decode_type slave_addr;
    logic [11:2] slot_base;
    logic [3:0] slot_be_n, byte_lane_enables_n_in, byte_lane_enables_n_out;
    logic [9:2] general_base, lower_addr_lines_in, lower_addr_lines_out;
    logic [31:0] bus_data_upper_addr_lines_in, bus_data_upper_addr_lines_out, read_data;
    logic [31:0] bus_word, seed;
    logic [11:10] slave_upper_decode_addr_inputs;
    logic bus_data_upper_addr_lines_oe, lower_addr_lines_oe, byte_lane_enables_n_oe;
    logic upper_addr_latch_strobe_n, transceiver_direction, start_n, slot_hit, general_hit;
    logic lane23_transceiver_enable_n, lane1_transceiver_enable_n, lane0_transceiver_enable_n;
    logic master_busy, strobe_prev, busy_prev;
    logic [31:0] exp_addr_q[$];
    logic [32:0] exp_rd_q[$];
    logic [32:0] rd_note;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    bus_buffer_control #(.GRANT_DELAY(2)) uut (.clk_sys, .rst_n, .master_start, .master_request,
        .cycle_end, .slave_cycle, .slave_write, .slot_base, .slot_be_n, .general_base,
        .bus_grant_n, .bus_data_upper_addr_lines_in, .slave_upper_decode_addr_inputs,
        .lower_addr_lines_in, .byte_lane_enables_n_in, .bus_data_upper_addr_lines_out,
        .bus_data_upper_addr_lines_oe, .lower_addr_lines_out, .lower_addr_lines_oe,
        .byte_lane_enables_n_out, .byte_lane_enables_n_oe, .upper_addr_latch_strobe_n,
        .transceiver_direction, .lane23_transceiver_enable_n, .lane1_transceiver_enable_n,
        .lane0_transceiver_enable_n, .start_n, .slot_hit, .general_hit, .read_data,
        .master_busy);

    bus_side_model far_side (.clk_sys, .grant_slow, .master_busy, .start_n,
        .slave_mode(slave_cycle), .bus_word, .slave_addr,
        .data_out(bus_data_upper_addr_lines_out), .data_oe(bus_data_upper_addr_lines_oe),
        .la_out(lower_addr_lines_out), .la_oe(lower_addr_lines_oe),
        .be_out(byte_lane_enables_n_out), .be_oe(byte_lane_enables_n_oe), .bus_grant_n,
        .data_in(bus_data_upper_addr_lines_in), .upper_in(slave_upper_decode_addr_inputs),
        .la_in(lower_addr_lines_in), .be_in(byte_lane_enables_n_in));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    // Address phase and read results are matched against the oldest note.
    always @(negedge clk_sys) begin
        if (upper_addr_latch_strobe_n === 1'b0 && strobe_prev === 1'b1) begin
            check("upper address", {bus_data_upper_addr_lines_out[31:10], 9'h0,
                  bus_data_upper_addr_lines_oe}, exp_addr_q.pop_front());
        end
        if (master_busy === 1'b0 && busy_prev === 1'b1) begin
            rd_note = exp_rd_q.pop_front();
            if (rd_note[32]) check("read data", read_data, rd_note[31:0]);
        end
        strobe_prev = upper_addr_latch_strobe_n;
        busy_prev = master_busy;
    end

    task automatic master_xfer(input logic [31:0] a, input logic [31:0] wd,
                               input logic [3:0] be, input logic wr);
        int n = 0;
        exp_addr_q.push_back({a[31:10], 9'h0, 1'b1});
        exp_rd_q.push_back({!wr, bus_word});
        master_request = '{a, wd, be, wr};
        master_start = 1'b1;
        @(negedge clk_sys) master_start = 1'b0;
        while (upper_addr_latch_strobe_n !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        check("grant wait", n < 40, 1);
        check("start before strobe", start_n, 1);
        @(negedge clk_sys);
        check("start low", start_n, 0);
        check("lower address", {lower_addr_lines_oe, lower_addr_lines_out}, {1'b1, a[9:2]});
        check("byte enables", {byte_lane_enables_n_oe, byte_lane_enables_n_out}, {1'b1, be});
        @(negedge clk_sys);
        check("start pulse", start_n, 1);
        check("latch", far_side.seen_la_q, a[9:2]);
        repeat (3) @(negedge clk_sys);
        check("direction", transceiver_direction, !wr);
        check("lanes", {lane23_transceiver_enable_n, lane1_transceiver_enable_n,
              lane0_transceiver_enable_n}, {&be[3:2], be[1:0]});
        check("data drive", bus_data_upper_addr_lines_oe, wr);
        check("write data", wr ? bus_data_upper_addr_lines_out : wd, wd);
        check("strobe held", upper_addr_latch_strobe_n, 0);
        cycle_end = 1'b1;
        @(negedge clk_sys) cycle_end = 1'b0;
        @(negedge clk_sys);
        check("cycle end", {upper_addr_latch_strobe_n, bus_data_upper_addr_lines_oe,
              lower_addr_lines_oe, byte_lane_enables_n_oe, lane0_transceiver_enable_n},
              5'b10001);
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic slave_try(input logic [11:2] a, input logic [3:0] be);
        slave_addr = '{a, be};
        slave_write = a[2] ^ be[0];
        slave_cycle = 1'b1;
        repeat (2) @(negedge clk_sys);
        master_start = 1'b1;
        @(negedge clk_sys) master_start = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("slot hit", slot_hit, {a, be} == {slot_base, slot_be_n});
        check("general hit", general_hit, a[9:2] == general_base);
        check("slave strobe", {upper_addr_latch_strobe_n, master_busy}, 2'b10);
        check("slave direction", {transceiver_direction, bus_data_upper_addr_lines_oe},
              {slave_write, !slave_write});
        check("slave lanes", {lane23_transceiver_enable_n, lane1_transceiver_enable_n,
              lane0_transceiver_enable_n}, {&be[3:2], be[1:0]});
        slave_cycle = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask

    initial begin
        {rst_n, master_start, cycle_end, slave_cycle, grant_slow} = '0;
        slave_write = 1'b1;
        master_request = '0;
        slave_addr = '0;
        seed = 32'h32df;
        seed = xs(seed);
        slot_base = seed[11:2];
        slot_be_n = seed[15:12];
        general_base = seed[9:2];
        bus_word = 32'h0;
        repeat (20) @(negedge clk_sys);
        check("reset pins", {bus_data_upper_addr_lines_oe, lower_addr_lines_oe,
              byte_lane_enables_n_oe, upper_addr_latch_strobe_n, transceiver_direction,
              lane23_transceiver_enable_n, lane1_transceiver_enable_n,
              lane0_transceiver_enable_n, start_n}, 9'h03f);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        for (int i = 0; i < 6; i++) begin
            grant_slow = i[1];
            seed = xs(seed);
            bus_word = xs(seed);
            master_xfer(seed, xs(bus_word), seed[7:4] ^ i[3:0], i[0]);
        end
        slave_try(slot_base, slot_be_n);
        slave_try({~slot_base[11:10], slot_base[9:2]}, slot_be_n);
        slave_try(slot_base, ~slot_be_n);
        slave_try(~slot_base, slot_be_n);
        print_verdict();
    end
endmodule
